// file: core/gptg_top.sv
// Purpose: Gated pulse train generator with AHB-Lite register access
// Assumes: Gate and external timebase synchronous to ref_clk_i
// Notes: Period and high time are in timebase ticks
`timescale 1ns/1ps
`default_nettype none
module gptg_top
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Counter pins
    input wire logic counter_gate_input,
    input wire logic ext_timebase_i,
    output logic counter_pulse_output
);
    gptg_pkg::gptg_cfg_t cfg_q;
    gptg_pkg::gptg_state_t state_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic start_p;
    logic stop_p;
    logic [15:0] tick_cnt_q;
    logic [15:0] pulses_q;
    logic [15:0] done_q;
    logic phase_w;
    logic out_q;
    logic div_q;
    logic tick;
    logic gate_ok;
    logic trig;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [15:0] eff_period;
    logic [15:0] eff_high;
    logic last_tick;
    logic [31:0] rd_d;
    logic [2:0] mode_w;
    // ==========================================================
    // Bus slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= hsel & hready & htrans[1] & hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end
    assign start_p = wr_pend_q && (wr_addr_q == gptg_pkg::GPTG_CTRL_OFF)
        && hwdata[gptg_pkg::GPTG_CTRL_START_BIT];
    assign stop_p = wr_pend_q && (wr_addr_q == gptg_pkg::GPTG_CTRL_OFF)
        && hwdata[gptg_pkg::GPTG_CTRL_STOP_BIT];
    assign mode_w = hwdata[gptg_pkg::GPTG_CTRL_MODE_LSB +: 3];
    // Configuration registers; illegal gate modes fall back to ungated
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            cfg_q.mode <= gptg_pkg::GPTG_GATE_NONE;
            cfg_q.ext_tb <= 1'b0;
            cfg_q.pol <= 1'b0;
            cfg_q.count <= gptg_pkg::GPTG_COUNT_RST;
            cfg_q.period <= gptg_pkg::GPTG_PERIOD_RST;
            cfg_q.high <= gptg_pkg::GPTG_HIGH_RST;
        end
        else if (wr_pend_q)
        begin
            case (wr_addr_q)
                gptg_pkg::GPTG_CTRL_OFF:
                begin
                    cfg_q.pol <= hwdata[gptg_pkg::GPTG_CTRL_POL_BIT];
                    cfg_q.ext_tb <= hwdata[gptg_pkg::GPTG_CTRL_EXT_BIT];
                    cfg_q.mode <= (mode_w > 3'h4) ? gptg_pkg::GPTG_GATE_NONE
                        : gptg_pkg::gptg_gate_mode_t'(mode_w);
                end
                gptg_pkg::GPTG_COUNT_OFF: cfg_q.count <= hwdata[15:0];
                gptg_pkg::GPTG_PERIOD_OFF: cfg_q.period <= hwdata[15:0];
                gptg_pkg::GPTG_HIGH_OFF: cfg_q.high <= hwdata[15:0];
                default: cfg_q <= cfg_q;
            endcase
        end
    end
    // Read mux, registered at the address phase; unmapped reads zero
    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (haddr[7:0])
            gptg_pkg::GPTG_CTRL_OFF: rd_d = {25'h0, cfg_q.mode, cfg_q.ext_tb, cfg_q.pol, 2'h0};
            gptg_pkg::GPTG_COUNT_OFF: rd_d = {16'h0, cfg_q.count};
            gptg_pkg::GPTG_PERIOD_OFF: rd_d = {16'h0, cfg_q.period};
            gptg_pkg::GPTG_HIGH_OFF: rd_d = {16'h0, cfg_q.high};
            gptg_pkg::GPTG_STAT_OFF: rd_d = {29'h0, out_q, state_q};
            gptg_pkg::GPTG_DONE_OFF: rd_d = {16'h0, done_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (hsel & hready & htrans[1] & ~hwrite)
        begin
            hrdata <= rd_d;
        end
    end
    // ==========================================================
    // Timebase: internal divides the reference, external rising edges count
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            div_q <= 1'b0;
        end
        else
        begin
            div_q <= ~div_q;
        end
    end
    gptg_edge u_edge
    (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .lvl_i({ext_timebase_i, counter_gate_input}),
        .rise_o(rise),
        .fall_o(fall)
    );
    assign tick = cfg_q.ext_tb ? rise[1] : div_q;
    // Level gating for modes one and two
    always_comb
    begin
        case (cfg_q.mode)
            gptg_pkg::GPTG_GATE_HIGH: gate_ok = counter_gate_input;
            gptg_pkg::GPTG_GATE_LOW: gate_ok = ~counter_gate_input;
            default: gate_ok = 1'b1;
        endcase
    end
    assign trig = ((cfg_q.mode == gptg_pkg::GPTG_GATE_RISE) && rise[0])
        || ((cfg_q.mode == gptg_pkg::GPTG_GATE_FALL) && fall[0]);
    // ==========================================================
    // Clamp period to three ticks and keep both phases non-empty
    always_comb
    begin
        eff_period = (cfg_q.period < gptg_pkg::GPTG_MIN_PERIOD) ?
            gptg_pkg::GPTG_MIN_PERIOD : cfg_q.period;
        if (cfg_q.high == 16'h0000)
        begin
            eff_high = 16'h0001;
        end
        else if (cfg_q.high >= eff_period)
        begin
            eff_high = eff_period - 16'h0001;
        end
        else
        begin
            eff_high = cfg_q.high;
        end
    end
    assign last_tick = tick_cnt_q == (eff_period - 16'h0001);
    // Edge modes rearm after each period when the count is zero
    function automatic logic trig_mode();
        trig_mode = (cfg_q.mode == gptg_pkg::GPTG_GATE_RISE)
            || (cfg_q.mode == gptg_pkg::GPTG_GATE_FALL);
    endfunction : trig_mode
    // ==========================================================
    // Sequencer
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state_q <= gptg_pkg::GPTG_ST_IDLE;
            tick_cnt_q <= 16'h0000;
            pulses_q <= 16'h0000;
            done_q <= 16'h0000;
        end
        else if (stop_p)
        begin
            state_q <= gptg_pkg::GPTG_ST_IDLE;
            tick_cnt_q <= 16'h0000;
        end
        else
        begin
            case (state_q)
                gptg_pkg::GPTG_ST_IDLE:
                begin
                    if (start_p)
                    begin
                        tick_cnt_q <= 16'h0000;
                        pulses_q <= 16'h0000;
                        done_q <= 16'h0000;
                        // Mode comes from the same write, so one word may set it and start
                        state_q <= (mode_w == gptg_pkg::GPTG_GATE_RISE
                            || mode_w == gptg_pkg::GPTG_GATE_FALL)
                            ? gptg_pkg::GPTG_ST_ARM : gptg_pkg::GPTG_ST_RUN;
                    end
                end
                gptg_pkg::GPTG_ST_ARM:
                begin
                    if (trig)
                    begin
                        tick_cnt_q <= 16'h0000;
                        state_q <= gptg_pkg::GPTG_ST_RUN;
                    end
                end
                gptg_pkg::GPTG_ST_RUN:
                begin
                    if (tick && gate_ok)
                    begin
                        if (!last_tick)
                        begin
                            tick_cnt_q <= tick_cnt_q + 16'h0001;
                        end
                        else
                        begin
                            tick_cnt_q <= 16'h0000;
                            pulses_q <= pulses_q + 16'h0001;
                            done_q <= done_q + 16'h0001;
                            if (cfg_q.count == 16'h0000 && trig_mode())
                            begin
                                state_q <= gptg_pkg::GPTG_ST_ARM;
                            end
                            else if (cfg_q.count != 16'h0000
                                && pulses_q + 16'h0001 == cfg_q.count)
                            begin
                                state_q <= gptg_pkg::GPTG_ST_IDLE;
                            end
                        end
                    end
                end
                default: state_q <= gptg_pkg::GPTG_ST_IDLE;
            endcase
        end
    end
    // ==========================================================
    // Output: delay phase first, then pulse phase of eff_high ticks
    always_comb
    begin
        phase_w = (state_q == gptg_pkg::GPTG_ST_RUN)
            && (tick_cnt_q >= (eff_period - eff_high));
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            out_q <= 1'b0;
        end
        else
        begin
            out_q <= phase_w ^ cfg_q.pol;
        end
    end
    assign counter_pulse_output = out_q;
    // ==========================================================
    // Checks
    idle_level_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q == gptg_pkg::GPTG_ST_IDLE) && $stable(cfg_q.pol) ##1
        $stable(cfg_q.pol) |-> counter_pulse_output == cfg_q.pol)
        else $error("idle output not at delay level");
    pol_map_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $stable(cfg_q.pol) |=> counter_pulse_output == ($past(phase_w) ^ $past(cfg_q.pol)))
        else $error("output polarity wrong");
    min_period_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        eff_period >= gptg_pkg::GPTG_MIN_PERIOD && eff_high < eff_period
        && eff_high != 16'h0000)
        else $error("period clamp broken");
    duty_pass_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (cfg_q.high != 16'h0000 && cfg_q.high < eff_period) |-> eff_high == cfg_q.high)
        else $error("high time not honoured");
    gate_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q == gptg_pkg::GPTG_ST_RUN && !gate_ok && !stop_p) |=>
        $stable(tick_cnt_q))
        else $error("counter moved while gated off");
    edge_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q == gptg_pkg::GPTG_ST_ARM && trig && !stop_p) |=>
        state_q == gptg_pkg::GPTG_ST_RUN)
        else $error("edge did not start train");
    oneshot_rearm_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q == gptg_pkg::GPTG_ST_RUN && tick && last_tick && !stop_p
        && cfg_q.count == 16'h0000 && trig_mode()) |=> state_q == gptg_pkg::GPTG_ST_ARM)
        else $error("one-shot did not rearm");
    endless_run_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q == gptg_pkg::GPTG_ST_RUN && cfg_q.count == 16'h0000 && !trig_mode()
        && !stop_p) |=> state_q == gptg_pkg::GPTG_ST_RUN)
        else $error("continuous train stopped");
    tb_select_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !cfg_q.ext_tb |-> tick == div_q)
        else $error("timebase select wrong");
    ungated_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q == gptg_pkg::GPTG_ST_IDLE && start_p && !stop_p
        && mode_w == gptg_pkg::GPTG_GATE_NONE) |=> state_q == gptg_pkg::GPTG_ST_RUN)
        else $error("software start failed");
    phase_order_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_q == gptg_pkg::GPTG_ST_RUN && tick_cnt_q == 16'h0000) |-> !phase_w)
        else $error("period does not open with delay");
endmodule : gptg_top
`default_nettype wire

// file: core/gptg_pkg.sv
// Purpose: Shared constants and types for the gated pulse train generator
// Assumes: 32-bit AHB-Lite register access, 20 MHz reference clock
// Notes: All offsets are byte addresses
package gptg_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] GPTG_CTRL_OFF = 8'h00;
    localparam logic [7:0] GPTG_COUNT_OFF = 8'h04;
    localparam logic [7:0] GPTG_PERIOD_OFF = 8'h08;
    localparam logic [7:0] GPTG_HIGH_OFF = 8'h0C;
    localparam logic [7:0] GPTG_STAT_OFF = 8'h10;
    localparam logic [7:0] GPTG_DONE_OFF = 8'h14;
    // ==========================================================
    // Control field positions
    localparam int GPTG_CTRL_START_BIT = 0;
    localparam int GPTG_CTRL_STOP_BIT = 1;
    localparam int GPTG_CTRL_POL_BIT = 2;
    localparam int GPTG_CTRL_EXT_BIT = 3;
    localparam int GPTG_CTRL_MODE_LSB = 4;
    // ==========================================================
    // Reset values and limits
    localparam logic [15:0] GPTG_PERIOD_RST = 16'h0004;
    localparam logic [15:0] GPTG_HIGH_RST = 16'h0002;
    localparam logic [15:0] GPTG_MIN_PERIOD = 16'h0003;
    localparam logic [15:0] GPTG_COUNT_RST = 16'h0000;
    // Timing
    localparam int GPTG_CLK_HZ = 20000000;
    localparam int GPTG_INT_TB_HZ = 10000000;
    localparam int GPTG_INT_DIV = GPTG_CLK_HZ / GPTG_INT_TB_HZ;
    // ==========================================================
    // Gate modes
    typedef enum logic [2:0]
    {
        GPTG_GATE_NONE = 3'b000,
        GPTG_GATE_HIGH = 3'b001,
        GPTG_GATE_LOW = 3'b010,
        GPTG_GATE_RISE = 3'b011,
        GPTG_GATE_FALL = 3'b100
    } gptg_gate_mode_t;
    typedef enum logic [1:0]
    {
        GPTG_ST_IDLE = 2'b00,
        GPTG_ST_ARM = 2'b01,
        GPTG_ST_RUN = 2'b10
    } gptg_state_t;
    // Configuration bundle
    typedef struct packed
    {
        gptg_gate_mode_t mode;
        logic ext_tb;
        logic pol;
        logic [15:0] count;
        logic [15:0] period;
        logic [15:0] high;
    } gptg_cfg_t;
endpackage : gptg_pkg

// file: core/gptg_edge.sv
// Purpose: Gate and timebase edge detector for the pulse generator
// Assumes: Inputs already synchronous to ref_clk_i
// Notes: Registered previous values, combinational edge flags
`timescale 1ns/1ps
`default_nettype none
module gptg_edge
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Sampled levels
    input wire logic [1:0] lvl_i,
    // Edge flags
    output logic [1:0] rise_o,
    output logic [1:0] fall_o
);
    logic [1:0] prev_q;
    // ==========================================================
    // Previous value store
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            prev_q <= 2'h0;
        end
        else
        begin
            prev_q <= lvl_i;
        end
    end
    // One generate loop iteration per watched signal
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_edge
            assign rise_o[gi] = lvl_i[gi] & ~prev_q[gi];
            assign fall_o[gi] = ~lvl_i[gi] & prev_q[gi];
        end
    endgenerate
endmodule : gptg_edge
`default_nettype wire

// file: verif/gptg_far_model.sv
// Purpose: Far side of the pulse generator: gate source, timebase source, output load
// Assumes: Bench sets the wanted gate level and timebase half period
// Notes: Load counts pulse phases and measures the last one in ref clocks
`timescale 1ns/1ps
`default_nettype none
module gptg_far_model
(
    // Clock
    input wire logic ref_clk_i,
    // Bench commands
    input wire logic gate_lvl_i,
    input wire logic [3:0] ext_half_i,
    input wire logic pol_i,
    input wire logic clr_i,
    // Pins
    input wire logic counter_pulse_output,
    output logic counter_gate_input,
    output logic ext_timebase_o,
    // Load observations
    output logic [15:0] pulses_o,
    output logic [15:0] width_o
);
    logic [3:0] div_q;
    logic [15:0] run_q;
    logic act_q;
    logic act;
    // ==========================================================
    // Sources
    // Pulse phase is whatever level differs from the delay level
    assign act = counter_pulse_output ^ pol_i;
    // Gate follows the bench; clear restarts the timebase low, so it never starts unknown
    always_ff @(posedge ref_clk_i)
    begin
        counter_gate_input <= gate_lvl_i;
        if (clr_i || ext_half_i == 4'h0)
        begin
            div_q <= 4'h0;
            ext_timebase_o <= 1'b0;
        end
        else if (div_q == ext_half_i - 4'h1)
        begin
            div_q <= 4'h0;
            ext_timebase_o <= ~ext_timebase_o;
        end
        else
            div_q <= div_q + 4'h1;
    end
    // ==========================================================
    // Load
    // Width is latched when the pulse phase ends, so a stuck output shows as no pulse
    always_ff @(posedge ref_clk_i)
    begin
        act_q <= act;
        if (clr_i)
        begin
            pulses_o <= 16'h0000;
            run_q <= 16'h0000;
            width_o <= 16'h0000;
        end
        else
        begin
            if (act && !act_q)
                pulses_o <= pulses_o + 16'h0001;
            run_q <= act ? run_q + 16'h0001 : 16'h0000;
            if (!act && act_q)
                width_o <= run_q;
        end
    end
endmodule : gptg_far_model
`default_nettype wire

// file: verif/gptg_top_tb_top.sv
// Purpose: Self-checking bench for the gated pulse train generator
// Assumes: Single slave on AHB-Lite, hready fed back from hreadyout
// Notes: Random trains from a fixed xorshift seed plus gate and clamp corners
`timescale 1ns/1ps
`default_nettype none
module gptg_top_tb_top;
    logic ref_clk_i, rst_i, hsel, hwrite, hreadyout, hresp;
    logic gate, ext_tb, pout, pol, clr, gate_lvl;
    logic [31:0] haddr, hwdata, hrdata, seed, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] ext_half;
    logic [15:0] pulses, width, n, p, h;
    int errors, n_tests;
    gptg_top dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .counter_gate_input(gate),
        .ext_timebase_i(ext_tb), .counter_pulse_output(pout));
    gptg_far_model far_u (.ref_clk_i(ref_clk_i), .gate_lvl_i(gate_lvl), .ext_half_i(ext_half),
        .pol_i(pol), .clr_i(clr), .counter_pulse_output(pout), .counter_gate_input(gate),
        .ext_timebase_o(ext_tb), .pulses_o(pulses), .width_o(width));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Pulse phase in ref clocks after the duty clamp, k clocks per tick
    function automatic logic [15:0] exp_w(input logic [15:0] pp, input logic [15:0] hh, input int k);
        logic [15:0] pe;
        logic [15:0] he;
        pe = (pp < 16'h0003) ? 16'h0003 : pp;
        he = (hh == 16'h0000) ? 16'h0001 : ((hh >= pe) ? pe - 16'h0001 : hh);
        return 16'(he * 16'(k));
    endfunction : exp_w
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Load observations: pulse counts and widths in ref clocks
    task automatic chk_load(input logic [15:0] got, input logic [15:0] exp);
        chk({16'h0000, got}, {16'h0000, exp});
    endtask : chk_load
    // Single pin levels and flags
    task automatic chk_pin(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk_pin
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    task automatic clk(input int c);
        repeat (c) @(posedge ref_clk_i);
    endtask : clk
    // Waits for hready; the bench timeout is the only way out of a stuck slave
    task automatic wait_rdy();
        @(posedge ref_clk_i);
        while (hreadyout !== 1'b1)
            @(posedge ref_clk_i);
    endtask : wait_rdy
    // One single-word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    // Loads a train, clears the load while starting so stale levels are not counted
    task automatic run(input logic [15:0] cn, input logic pl, input logic ex, input logic [2:0] md);
        bus(1'b1, gptg_pkg::GPTG_CTRL_OFF, 32'h00000002);
        bus(1'b1, gptg_pkg::GPTG_COUNT_OFF, {16'h0000, cn});
        bus(1'b1, gptg_pkg::GPTG_PERIOD_OFF, {16'h0000, p});
        bus(1'b1, gptg_pkg::GPTG_HIGH_OFF, {16'h0000, h});
        bus(1'b1, gptg_pkg::GPTG_CTRL_OFF, {25'h0, md, ex, pl, 2'h0});
        pol <= pl;
        clr <= 1'b1;
        bus(1'b1, gptg_pkg::GPTG_CTRL_OFF, {25'h0, md, ex, pl, 2'h1});
        clr <= 1'b0;
    endtask : run
    task automatic wait_idle();
        int i;
        clk(4);
        for (i = 0; i < 300; i++)
        begin
            bus(1'b0, gptg_pkg::GPTG_STAT_OFF, 32'h0);
            if (rd[1:0] == 2'h0)
                break;
        end
        // Lets the output and the load's width latch settle after the last period
        clk(2);
    endtask : wait_idle
    // ==========================================================
    // Clock and watchdog
    initial
    begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    initial
    begin
        clk(40000);
        errors++;
        final_report();
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        rst_i = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; gate_lvl = 1'b0; ext_half = 4'h3; pol = 1'b0;
        clr = 1'b1; seed = 32'h0000002A; errors = 0; n_tests = 0;
        clk(10);
        rst_i <= 1'b0;
        clr <= 1'b0;
        chk_pin(pout, 1'b0);
        chk_pin(hresp, 1'b0);
        chk_pin(hreadyout, 1'b1);
        bus(1'b0, gptg_pkg::GPTG_PERIOD_OFF, 32'h0);
        chk(rd, 32'h00000004);
        bus(1'b0, gptg_pkg::GPTG_HIGH_OFF, 32'h0);
        chk(rd, 32'h00000002);
        bus(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        // Undefined gate mode must read back as ungated, flags kept
        bus(1'b1, gptg_pkg::GPTG_CTRL_OFF, 32'h0000007C);
        bus(1'b0, gptg_pkg::GPTG_CTRL_OFF, 32'h0);
        chk(rd, 32'h0000000C);
        // Finite trains, random shape, clamp corners, both timebases
        for (int i = 0; i < 8; i++)
        begin
            n = 16'(rnd() % 4 + 1);
            p = 16'(rnd() % 6 + 3);
            h = (i == 4) ? 16'h0 : ((i == 5) ? p : 16'(rnd() % (p - 1) + 1));
            run(n, 1'(rnd() % 2), i >= 6, 3'h0);
            wait_idle();
            chk_load(pulses, n);
            chk_load(width, exp_w(p, h, i >= 6 ? 6 : 2));
            chk_pin(pout, pol);
            bus(1'b0, gptg_pkg::GPTG_STAT_OFF, 32'h0);
            chk(rd, {29'h0, pol, 2'h0});
            bus(1'b0, gptg_pkg::GPTG_DONE_OFF, 32'h0);
            chk(rd, {16'h0000, n});
        end
        // Endless train keeps running
        p = 16'h0004;
        h = 16'h0002;
        run(16'h0, 1'b0, 1'b0, 3'h0);
        clk(200);
        chk_pin(pulses >= 16'h0014, 1'b1);
        bus(1'b0, gptg_pkg::GPTG_STAT_OFF, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h00000002);
        // Level gates: blocked level first, then open
        for (int md = 1; md <= 2; md++)
        begin
            gate_lvl <= (md == 2);
            run(16'h3, 1'b0, 1'b0, 3'(md));
            clk(60);
            chk_load(pulses, 16'h0000);
            gate_lvl <= (md != 2);
            wait_idle();
            chk_load(pulses, 16'h0003);
        end
        // Edge starts, one pulse per qualifying edge when count is zero
        for (int md = 3; md <= 4; md++)
        begin
            gate_lvl <= (md == 4);
            run(16'h0, 1'b1, 1'b0, 3'(md));
            clk(40);
            chk_load(pulses, 16'h0000);
            for (int e = 1; e <= 3; e++)
            begin
                gate_lvl <= (md != 4);
                clk(30);
                gate_lvl <= (md == 4);
                clk(30);
                chk_load(pulses, 16'(e));
            end
        end
        final_report();
    end
endmodule : gptg_top_tb_top
`default_nettype wire
